// *** core/adc_ctrl_pkg.sv ***
// Shared constants and carrier types for the converter control port
package adc_ctrl_pkg;
    localparam int CHANNELS = 4;
    localparam int DATA_W = 12;
    localparam int FIFO_DEPTH = 8;
    // Conversion clocks per channel in external clock mode
    localparam int EXT_CONV_CYCLES = 14;
    // Internal conversion time in ns and derived system cycles (4 ns period, rounded down)
    localparam int INT_CONV_NS = 1650;
    localparam int CLK_PERIOD_NS = 4;
    localparam int INT_CONV_CYCLES = INT_CONV_NS / CLK_PERIOD_NS;
    localparam logic [3:0] CHAN_SEL_RESET = 4'h0;
    localparam logic [9:0] COUNT_RESET = 10'h000;

    typedef struct packed {
        logic [1:0] chan;
        logic [DATA_W-1:0] value;
    } result_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_STEP = 3'b100
    } conv_state_t;
endpackage : adc_ctrl_pkg

// *** core/result_fifo.sv ***
// Parameterised first-in first-out buffer for conversion results
`timescale 1ns/1ps
`default_nettype none
module result_fifo
    import adc_ctrl_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    always_comb
    begin
        in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid = wr_ptr != rd_ptr;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
        out_data = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule : result_fifo
`default_nettype wire

// *** core/adc_ctrl.sv ***
// Control and host port of the four-channel simultaneous sampling converter
// Notes on behaviour
// - Convert-start rising edge holds all channels and starts the sequence.
// - Channel choice is captured at convert-start rise and kept for the sequence.
// - Busy rises with convert-start and falls after the last selected channel.
// - First-result flag is high exactly while the pointer addresses register one.
// - Read and write strobes are honoured only while chip select is low.
// - Data outputs are driven only while read strobe and chip select are low.
// - Write strobe rise with select low, read high stores bits three..zero.
// - Source select low takes the sequence from the hardware channel pins.
// - Source select high takes the sequence from the channel select register.
// - External clock mode spends fourteen conversion clocks on each channel.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Conversion control
    input wire logic convert_start,
    input wire logic [3:0] hw_channel_pins,
    input wire logic sw_source_sel,
    input wire logic ext_clock_mode,
    input wire logic conversion_clock_in,
    // Converter core results, sample hold and conversion status outputs
    input wire logic [DATA_W-1:0] core_result [CHANNELS],
    output logic [CHANNELS-1:0] hold,
    output logic end_of_conv,
    output logic busy,
    output logic first_result_flag,
    // Host parallel port
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] low_data_bits,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic [3:0] chan_sel_reg
);
    conv_state_t state;
    conv_state_t next_state;
    logic conv_d;
    logic wr_d;
    logic rd_d;
    logic clk_in_d;
    logic [3:0] seq;
    logic [3:0] next_seq;
    logic [3:0] next_chan_sel;
    logic [1:0] chan;
    logic [1:0] next_chan;
    logic [9:0] count;
    logic [9:0] next_count;
    logic [DATA_W-1:0] next_data_out;
    logic [1:0] rd_ptr;
    logic [1:0] next_rd_ptr;
    logic [3:0] fill_mask;
    logic [3:0] next_fill_mask;
    logic [2:0] next_pick;
    // Ticks in the current conversion, kept apart from the sequencer's own count
    logic [4:0] tick_seen;
    logic [4:0] next_tick_seen;
    logic conv_rise;
    logic wr_rise;
    logic rd_fall;
    logic clk_tick;
    logic conv_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    result_word_t fifo_in;
    result_word_t fifo_out;
    logic pop;

    // Lowest selected channel at or after a starting index
    function automatic logic [2:0] next_sel(input logic [3:0] mask, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 3; i >= 0; i--)
        begin
            if (mask[i] && 3'(i) >= from)
                r = 3'(i);
        end
        return r;
    endfunction : next_sel

    always_comb
    begin
        conv_rise = convert_start && !conv_d;
        wr_rise = wr_n && !wr_d;
        rd_fall = !rd_n && rd_d && !cs_n;
        clk_tick = conversion_clock_in && !clk_in_d;
        pop = rd_fall;
        next_pick = next_sel(seq, {1'b0, chan});
        conv_done = ext_clock_mode ? (clk_tick && count == 10'(EXT_CONV_CYCLES - 1))
                                   : (count == 10'(INT_CONV_CYCLES - 1));
    end

    // Channel select register
    always_comb
    begin
        next_chan_sel = chan_sel_reg;
        if (wr_rise && !cs_n && rd_n)
            next_chan_sel = low_data_bits;
    end

    // Conversion sequencer
    always_comb
    begin
        next_state = state;
        next_seq = seq;
        next_chan = chan;
        next_count = count;
        end_of_conv = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_count = COUNT_RESET;
                if (conv_rise)
                begin
                    next_seq = sw_source_sel ? chan_sel_reg : hw_channel_pins;
                    next_state = ST_STEP;
                    next_chan = 2'h0;
                end
            end
            ST_STEP:
            begin
                // A full buffer stalls the sequencer until the host reads
                if (next_pick == 3'h4)
                    next_state = ST_IDLE;
                else if (fifo_in_ready)
                begin
                    next_chan = next_pick[1:0];
                    next_state = ST_CONV;
                    next_count = COUNT_RESET;
                end
            end
            ST_CONV:
            begin
                if (!ext_clock_mode || clk_tick)
                    next_count = count + 10'h001;
                if (conv_done)
                begin
                    end_of_conv = 1'b1;
                    next_seq[chan] = 1'b0;
                    next_state = ST_STEP;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_comb
    begin
        busy = (state != ST_IDLE);
        hold = busy ? {CHANNELS{1'b1}} : '0;
        fifo_in.chan = chan;
        fifo_in.value = core_result[chan];
        data_oe_n = !(!cs_n && !rd_n);
        first_result_flag = (rd_ptr == 2'h0);
    end

    // Read pointer and output word
    always_comb
    begin
        next_rd_ptr = rd_ptr;
        next_data_out = data_out;
        next_fill_mask = fill_mask;
        // A word popped in the cycle of a new start must still reach the output
        if (pop && fifo_out_valid)
        begin
            next_data_out = fifo_out.value;
            next_rd_ptr = rd_ptr + 2'h1;
        end
        if (conv_rise && state == ST_IDLE)
        begin
            next_rd_ptr = 2'h0;
            next_fill_mask = sw_source_sel ? chan_sel_reg : hw_channel_pins;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            seq <= CHAN_SEL_RESET;
            chan <= 2'h0;
            count <= COUNT_RESET;
            chan_sel_reg <= CHAN_SEL_RESET;
            conv_d <= 1'b0;
            wr_d <= 1'b1;
            rd_d <= 1'b1;
            clk_in_d <= 1'b0;
            rd_ptr <= 2'h0;
            data_out <= '0;
            fill_mask <= CHAN_SEL_RESET;
        end
        else
        begin
            state <= next_state;
            seq <= next_seq;
            chan <= next_chan;
            count <= next_count;
            chan_sel_reg <= next_chan_sel;
            conv_d <= convert_start;
            wr_d <= wr_n;
            rd_d <= rd_n;
            clk_in_d <= conversion_clock_in;
            rd_ptr <= next_rd_ptr;
            data_out <= next_data_out;
            fill_mask <= next_fill_mask;
        end
    end

    // Shadow tick count, so the external clock check does not trust the sequencer
    always_comb
    begin
        next_tick_seen = tick_seen;
        if (state != ST_CONV)
            next_tick_seen = '0;
        else if (clk_tick)
            next_tick_seen = tick_seen + 5'h01;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tick_seen <= '0;
        else
            tick_seen <= next_tick_seen;
    end

    result_fifo #(
        .WIDTH($bits(result_word_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(end_of_conv),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out)
    );

    sequence conv_edge_s;
        $rose(convert_start) && state == ST_IDLE;
    endsequence

    sequence busy_rise_s;
        ##1 busy;
    endsequence

    sequence read_pop_s;
        rd_fall && fifo_out_valid && !(conv_rise && state == ST_IDLE);
    endsequence

    sequence last_done_s;
        state == ST_STEP && next_pick == 3'h4;
    endsequence

    busy_on_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        conv_edge_s |-> busy_rise_s) else $error("busy did not rise after convert start");
    hold_all_a: assert property (@(posedge sys_clk) disable iff (rst)
        busy |-> hold == 4'hf) else $error("hold not applied to all channels");
    seq_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        (conv_edge_s and sw_source_sel) |=> seq == $past(chan_sel_reg)) else $error("software choice not captured");
    hw_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        (conv_edge_s and !sw_source_sel) |=> seq == $past(hw_channel_pins)) else $error("pin choice not captured");
    first_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        conv_edge_s |=> first_result_flag) else $error("first flag not set by convert start");
    out_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cs_n || rd_n) |-> data_oe_n) else $error("outputs driven outside read");
    write_store_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(wr_n) && !cs_n && rd_n |=> chan_sel_reg == $past(low_data_bits)) else $error("channel select not stored");
    write_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cs_n || !rd_n) |=> $stable(chan_sel_reg)) else $error("channel select changed while ignored");
    int_conv_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        end_of_conv && !ext_clock_mode |->
            $past(state, INT_CONV_CYCLES - 1) == ST_CONV && $past(state, INT_CONV_CYCLES) == ST_STEP)
        else $error("internal conversion length wrong");
    first_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        (read_pop_s and rd_ptr == 2'h0) |=> !first_result_flag) else $error("first flag high after read");
    busy_end_a: assert property (@(posedge sys_clk) disable iff (rst)
        last_done_s |=> !busy && seq == 4'h0) else $error("busy outlived the sequence");
    busy_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        busy && !(state == ST_STEP && next_pick == 3'h4) |=> busy) else $error("busy fell early");
    oe_on_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!cs_n && !rd_n) |-> !data_oe_n) else $error("outputs not driven during read");
    deselect_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        cs_n |=> $stable(data_out)) else $error("read honoured without chip select");
    chan_in_choice_a: assert property (@(posedge sys_clk) disable iff (rst)
        end_of_conv |-> fill_mask[chan]) else $error("converted channel outside captured choice");
    seq_shrink_a: assert property (@(posedge sys_clk) disable iff (rst)
        busy |=> (seq & ~$past(seq)) == 4'h0) else $error("channel choice grew during sequence");
    ext_conv_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        end_of_conv && ext_clock_mode |-> clk_tick && tick_seen == 5'(EXT_CONV_CYCLES - 1))
        else $error("external conversion length wrong");
endmodule : adc_ctrl
`default_nettype wire

// *** dv/host_model.sv ***
// Host processor model driving the converter's parallel port
`timescale 1ns/1ps
`default_nettype none
module host_model
    import adc_ctrl_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Parallel port
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] low_data_bits,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n
);
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        low_data_bits = 4'h0;
    end
    task automatic write_sel(input logic [3:0] v, input logic cs_lvl, input logic rd_lvl);
        @(posedge sys_clk) #1;
        cs_n = cs_lvl;
        rd_n = rd_lvl;
        wr_n = 1'b0;
        low_data_bits = v;
        @(posedge sys_clk) #1;
        wr_n = 1'b1;
        @(posedge sys_clk) #1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        // Released lines show the inverse so stale data cannot pass
        low_data_bits = ~v;
    endtask : write_sel
    task automatic read_word(input logic cs_lvl, output logic [DATA_W-1:0] d, output logic oe_n);
        @(posedge sys_clk) #1;
        wr_n = 1'b1;
        cs_n = cs_lvl;
        rd_n = 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk) #1;
        d = data_out;
        oe_n = data_oe_n;
        cs_n = 1'b1;
        rd_n = 1'b1;
        @(posedge sys_clk) #1;
    endtask : read_word
endmodule : host_model
`default_nettype wire

// *** dv/simultaneous_adc_control_port_bench.sv ***
// Self-checking bench for the converter control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL %0t got %h expected %h", $time, (a), (b)); end end
module simultaneous_adc_control_port_bench
    import adc_ctrl_pkg::*;
;
    typedef struct packed {logic src; logic [3:0] hw; logic [3:0] sw;} row_t;
    logic sys_clk, rst, convert_start, sw_source_sel, ext_clock_mode, conversion_clock_in;
    logic cs_n, rd_n, wr_n, end_of_conv, busy, first_result_flag, data_oe_n, oe, cc_prev;
    logic [3:0] hw_channel_pins, low_data_bits, chan_sel_reg, hold, mask;
    logic [DATA_W-1:0] core_res [CHANNELS];
    logic [DATA_W-1:0] data_out, d;
    int error_cnt, total_checks, ccnt, first_cnt, p, nr, eoc_total, eoc_tick;
    row_t rows [4] = '{'{1'b0, 4'h5, 4'ha}, '{1'b1, 4'h5, 4'ha}, '{1'b0, 4'hf, 4'h0}, '{1'b1, 4'h3, 4'hc}};
    adc_ctrl i_adc_ctrl (.sys_clk(sys_clk), .rst(rst), .convert_start(convert_start),
        .hw_channel_pins(hw_channel_pins), .sw_source_sel(sw_source_sel), .ext_clock_mode(ext_clock_mode),
        .conversion_clock_in(conversion_clock_in), .core_result(core_res), .hold(hold),
        .end_of_conv(end_of_conv), .busy(busy), .first_result_flag(first_result_flag), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .low_data_bits(low_data_bits), .data_out(data_out),
        .data_oe_n(data_oe_n), .chan_sel_reg(chan_sel_reg));
    host_model i_host_model (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .low_data_bits(low_data_bits), .data_out(data_out), .data_oe_n(data_oe_n));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Free-running conversion clock at a quarter of the system rate
    initial
    begin
        conversion_clock_in = 1'b0;
        forever
        begin
            repeat (2) @(posedge sys_clk);
            #1 conversion_clock_in = ~conversion_clock_in;
        end
    end
    always @(posedge sys_clk)
    begin
        if (conversion_clock_in && !cc_prev)
            ccnt++;
        cc_prev = conversion_clock_in;
        // Pulse taken at the edge that consumes it, as the buffer does
        if (end_of_conv === 1'b1)
        begin
            eoc_total++;
            eoc_tick = ccnt;
        end
    end
    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic run_seq(input logic [3:0] hw, input int lim, input logic must_end, output int pulses);
        int n;
        int base;
        int start_eoc;
        @(posedge sys_clk) #1;
        hw_channel_pins = hw;
        convert_start = 1'b1;
        base = ccnt;
        start_eoc = eoc_total;
        for (n = 0; n < 10 && busy !== 1'b1; n++)
            @(posedge sys_clk) #1;
        `CHK(busy, 1'b1)
        `CHK(hold, 4'hf)
        convert_start = 1'b0;
        hw_channel_pins = ~hw;
        for (n = 0; n < lim && busy === 1'b1; n++)
            @(posedge sys_clk) #1;
        pulses = eoc_total - start_eoc;
        // Ticks up to and including the one that ended the latest conversion
        first_cnt = eoc_tick - base;
        if (busy !== 1'b0 && must_end)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask : run_seq
    initial
    begin
        rst = 1'b1;
        convert_start = 1'b0;
        sw_source_sel = 1'b0;
        ext_clock_mode = 1'b0;
        hw_channel_pins = 4'h0;
        for (int i = 0; i < CHANNELS; i++)
            core_res[i] = 12'h100 + DATA_W'(i);
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        `CHK({busy, first_result_flag, chan_sel_reg, data_oe_n}, {1'b0, 1'b1, CHAN_SEL_RESET, 1'b1})
        foreach (rows[r])
        begin
            i_host_model.write_sel(rows[r].sw, 1'b0, 1'b1);
            `CHK(chan_sel_reg, rows[r].sw)
            sw_source_sel = rows[r].src;
            mask = rows[r].src ? rows[r].sw : rows[r].hw;
            run_seq(rows[r].hw, 8000, 1'b1, p);
            `CHK(p, $countones(mask))
            `CHK(first_result_flag, 1'b1)
            nr = 0;
            for (int c = 0; c < CHANNELS; c++)
                if (mask[c])
                begin
                    i_host_model.read_word(1'b0, d, oe);
                    nr++;
                    `CHK(d, core_res[c])
                    `CHK(oe, 1'b0)
                    // Pointer wraps back to the first register after the fourth read
                    `CHK(first_result_flag, nr % CHANNELS == 0)
                end
        end
        // Refused writes and a deselected read
        i_host_model.write_sel(4'h9, 1'b1, 1'b1);
        `CHK(chan_sel_reg, 4'hc)
        i_host_model.write_sel(4'h6, 1'b0, 1'b0);
        `CHK(chan_sel_reg, 4'hc)
        i_host_model.read_word(1'b1, d, oe);
        `CHK({oe, d}, {1'b1, core_res[3]})
        // External clock: one channel
        ext_clock_mode = 1'b1;
        sw_source_sel = 1'b0;
        run_seq(4'h2, 8000, 1'b1, p);
        `CHK(p, 1)
        `CHK(first_cnt inside {EXT_CONV_CYCLES, EXT_CONV_CYCLES + 1}, 1'b1)
        i_host_model.read_word(1'b0, d, oe);
        `CHK(d, core_res[1])
        // Fill the buffer until the sequencer stalls, then drain it
        ext_clock_mode = 1'b0;
        run_seq(4'hf, 8000, 1'b1, p);
        run_seq(4'hf, 8000, 1'b1, p);
        run_seq(4'hf, 1800, 1'b0, p);
        `CHK(busy, 1'b1)
        for (int k = 0; k < 8; k++)
        begin
            i_host_model.read_word(1'b0, d, oe);
            `CHK(d, core_res[k % 4])
        end
        run_seq(4'h0, 3000, 1'b1, p);
        for (int k = 0; k < 5; k++)
        begin
            i_host_model.read_word(1'b0, d, oe);
            `CHK(d, core_res[k < 4 ? k : 3])
        end
        wrap_up();
    end
endmodule : simultaneous_adc_control_port_bench
`default_nettype wire
